// File: ptg_line_model.sv
// ptg_line_model: far-end line equipment looping every tx byte back to rx.
// assumes stall and corrupt are driven off the rising edge by the bench.
`timescale 1ns/10ps
module ptg_line_model
    import ptg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic stall,
    input wire logic corrupt,
    input wire logic tx_out_valid,
    input wire ptg_slot_type tx_out,
    output logic tx_out_ready,
    output logic rx_in_valid,
    output ptg_slot_type rx_in
);
    assign tx_out_ready = !stall;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_in_valid <= 1'b0;
            rx_in <= '0;
        end else if (tx_out_valid && tx_out_ready) begin
            rx_in_valid <= 1'b1;
            rx_in <= tx_out ^ {15'h0, corrupt};
        end else begin
            rx_in_valid <= 1'b0;
            // idle line toggles so a stale byte never looks valid
            rx_in <= ~rx_in;
        end
    end
endmodule // ptg_line_model

// File: ptg_monitor.sv
// ptg_monitor: port-level checks of ptg_top, attached by bind.
// assumes one clock, srst synchronous active high, zero-wait bus slave.
`timescale 1ns/10ps
module ptg_monitor
    import ptg_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic tx_in_valid,
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic tx_out_ready,
    input wire ptg_slot_type tx_out,
    input wire logic [2:0] test_framer,
    input wire logic diag_loopback
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] idx_reg;
    logic [31:0] wd_reg;
    logic mapped;
    // broad superset, so a register inside the known map is never judged unmapped
    assign mapped = idx_reg inside {IDX_FRAMER_TEST_SELECT, IDX_LOOPBACK_CONTROL,
        [IDX_PATTERN_DETECTOR_CONFIG:8'h7F], [IDX_RX_PAYLOAD_ENABLE:IDX_TX_PAYLOAD_INDIRECT_DATA]};
    always_ff @(posedge core_clk) begin
        wd_reg <= hwdata;
        if (srst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 8'h00;
        end else begin
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            rd_pend_reg <= hsel && htrans[1] && hready && !hwrite;
            if (hsel && htrans[1] && hready) begin
                idx_reg <= haddr[9:2];
            end
        end
    end
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_zero_wait; !$past(srst) |-> hreadyout; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("wait state seen");
    property p_rst_vals; $fell(srst) |-> test_framer == 3'h0 && !diag_loopback && !tx_out_valid;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
    property p_sel_wr; wr_pend_reg && idx_reg == IDX_FRAMER_TEST_SELECT |=>
        test_framer == wd_reg[7:FRAMER_SEL_LSB]; endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("framer select not taken");
    property p_lb_wr; wr_pend_reg && idx_reg == IDX_LOOPBACK_CONTROL |=>
        diag_loopback == wd_reg[LOOPBACK_DIAG_DIGITAL_BIT]; endproperty
    a_lb_wr: assert property (p_lb_wr) else $error("loopback not taken");
    property p_sel_rd; rd_pend_reg && idx_reg == IDX_FRAMER_TEST_SELECT |->
        hrdata[7:FRAMER_SEL_LSB] == test_framer; endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("framer select readback");
    property p_lb_rd; rd_pend_reg && idx_reg == IDX_LOOPBACK_CONTROL |->
        hrdata[LOOPBACK_DIAG_DIGITAL_BIT] == diag_loopback; endproperty
    a_lb_rd: assert property (p_lb_rd) else $error("loopback readback");
    property p_unmapped; rd_pend_reg && !mapped |-> hrdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_fifo_out; tx_in_valid && tx_in_ready |=> tx_out_valid; endproperty
    a_fifo_out: assert property (p_fifo_out) else $error("pushed byte not offered");
    property p_hold; tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out);
    endproperty
    a_hold: assert property (p_hold) else $error("tx byte changed while stalled");
endmodule // ptg_monitor

bind ptg_top ptg_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.core_clk(core_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_out(tx_out), .test_framer(test_framer),
    .diag_loopback(diag_loopback));

// File: ptg_pkg.sv
// ptg_pkg: constants, register indices and types of the pattern test block.
// assumes a 32-bit AHB-Lite slave port; register index = byte address / 4.
package ptg_pkg;

    // printed register offsets, kept as word indices
    localparam logic [7:0] IDX_FRAMER_TEST_SELECT = 8'h0C;
    localparam logic [7:0] IDX_PATTERN_DETECTOR_CONFIG = 8'h70;
    localparam logic [7:0] IDX_PATTERN_STATUS = 8'h71;
    localparam logic [7:0] IDX_PATTERN_LENGTH = 8'h72;
    localparam logic [7:0] IDX_FEEDBACK_TAP = 8'h73;
    localparam logic [7:0] IDX_PATTERN_INSERT_FIRST = 8'h78;
    localparam logic [7:0] IDX_PATTERN_INSERT_LAST = 8'h7B;
    localparam logic [7:0] IDX_PATTERN_RESULT = 8'h7C;
    localparam logic [7:0] IDX_LOOPBACK_CONTROL = 8'h87;
    localparam logic [7:0] IDX_RX_PAYLOAD_ENABLE = 8'hDC;
    localparam logic [7:0] IDX_RX_PAYLOAD_INDIRECT_ADDRESS = 8'hDE;
    localparam logic [7:0] IDX_RX_PAYLOAD_INDIRECT_DATA = 8'hDF;
    localparam logic [7:0] IDX_TX_PAYLOAD_ENABLE = 8'hE0;
    localparam logic [7:0] IDX_TX_PAYLOAD_INDIRECT_ADDRESS = 8'hE2;
    localparam logic [7:0] IDX_TX_PAYLOAD_INDIRECT_DATA = 8'hE3;

    // field positions
    localparam int FRAMER_SEL_LSB = 5;
    localparam int CFG_AUTO_RESYNC_BIT = 1;
    localparam int CFG_REPETITIVE_PATTERN_SELECT_BIT = 4;
    localparam int CFG_TX_PATTERN_INVERT_BIT = 5;
    localparam int CFG_RX_PATTERN_INVERT_BIT = 6;
    localparam int CFG_ERROR_COUNTER_BIT = 7;
    localparam int STAT_BIT_ERROR_FLAG_BIT = 2;
    localparam int STAT_DETECTOR_SYNC_FLAG_BIT = 4;
    localparam int LOOPBACK_DIAG_DIGITAL_BIT = 2;
    localparam int PAYLOAD_ENABLE_BIT = 0;
    localparam int TX_TEST_INSERT_BIT = 3;
    localparam int RX_TEST_EXTRACT_BIT = 7;
    localparam logic [2:0] PAYLOAD_TABLE_SEL = 3'b001;

    // reset values and detector counts
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] SYNC_GOOD_BYTES = 3'd4;
    localparam logic [2:0] LOSS_BAD_BYTES = 3'd4;
    localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;

    typedef struct packed {
        logic [2:0] framer;
        logic [4:0] slot;
        logic [7:0] data;
    } ptg_slot_type;

    typedef struct packed {
        logic [31:0] st;
        logic [7:0] data;
        logic [3:0] errs;
    } ptg_step_type;

endpackage

// File: ptg_top.sv
// ptg_top: shared pseudo-random / repetitive pattern generator and detector
// serving one selected framer, with payload control tables and a tx fifo.
// assumes one 20 MHz clock, stream inputs synchronous to it, AHB-Lite master.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps

module ptg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ptg_fifo_state_type;

    ptg_fifo_state_type st_reg;
    ptg_fifo_state_type st_next;
    logic push;
    logic pop;

    assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data = st_reg.mem[st_reg.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // ptg_fifo

////////////////////////////////////////////////////////////////////////////////

module ptg_top
    import ptg_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire ptg_slot_type tx_in,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output ptg_slot_type tx_out,
    input wire logic rx_in_valid,
    input wire ptg_slot_type rx_in,
    output logic [2:0] test_framer,
    output logic diag_loopback
);
    typedef struct packed {
        logic hready;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [7:0] fsel;
        logic [7:0] cfg;
        logic [7:0] len;
        logic [7:0] tap;
        logic [3:0][7:0] ins;
        logic [7:0] loopb;
        logic [7:0] rx_en;
        logic [7:0] tx_en;
        logic [7:0] tx_iaddr;
        logic [7:0] tx_idata;
        logic [7:0] rx_iaddr;
        logic [7:0] rx_idata;
        logic [31:0][7:0] tx_tbl;
        logic [31:0][7:0] rx_tbl;
        logic gen_run;
        logic [31:0] gen_lfsr;
        logic [31:0] det_lfsr;
        logic sync;
        logic bit_error_flag;
        logic [2:0] good_cnt;
        logic [2:0] bad_cnt;
        logic [15:0] err_cnt;
        logic [7:0] last_rx;
    } ptg_state_type;

    ptg_state_type st_reg;
    ptg_state_type st_next;
    logic [7:0] addr_idx;
    logic addr_phase;
    logic fifo_in_ready;
    ptg_slot_type fifo_in;
    ptg_slot_type fifo_out;
    logic fifo_out_valid;

    // one bit per step: repeat mode rotates, else feeds back two taps.
    // out of sync the detector shifts in what it receives (self-seeding).
    function automatic ptg_step_type ptg_step(
        input logic [31:0] s,
        input logic [7:0] len,
        input logic [7:0] tap,
        input logic rep,
        input logic load,
        input logic [7:0] rx
    );
        ptg_step_type r;
        logic b;
        r.st = s;
        r.data = '0;
        r.errs = '0;
        for (int i = 7; i >= 0; i--) begin
            b = rep ? r.st[len[4:0]] : (r.st[len[4:0]] ^ r.st[tap[4:0]]);
            r.data[i] = b;
            if (rx[i] != b) begin
                r.errs = r.errs + 4'd1;
            end
            r.st = {r.st[30:0], load ? rx[i] : b};
        end
        return r;
    endfunction

    assign addr_idx = haddr[9:2];
    assign addr_phase = hsel & htrans[1] & hready;

    //////////////////////////////////////////////////////////////////////////

    always_comb begin
        ptg_step_type g;
        ptg_step_type d;
        logic [7:0] rd;
        logic [7:0] rxb;
        logic tx_hit;
        logic rx_hit;
        g = '0;
        d = '0;
        rd = '0;
        rxb = '0;
        tx_hit = 1'b0;
        rx_hit = 1'b0;
        st_next = st_reg;
        st_next.hready = 1'b1;

        // register writes land in the data phase
        if (st_reg.wr_pend) begin
            st_next.wr_pend = 1'b0;
            case (st_reg.wr_idx)
                IDX_FRAMER_TEST_SELECT: st_next.fsel = hwdata[7:0];
                IDX_PATTERN_DETECTOR_CONFIG: st_next.cfg = hwdata[7:0];
                IDX_PATTERN_LENGTH: st_next.len = hwdata[7:0];
                IDX_FEEDBACK_TAP: st_next.tap = hwdata[7:0];
                IDX_PATTERN_RESULT: st_next.err_cnt = '0;
                IDX_LOOPBACK_CONTROL: st_next.loopb = hwdata[7:0];
                IDX_RX_PAYLOAD_ENABLE: st_next.rx_en = hwdata[7:0];
                IDX_TX_PAYLOAD_ENABLE: st_next.tx_en = hwdata[7:0];
                IDX_TX_PAYLOAD_INDIRECT_DATA: begin
                    if (st_reg.tx_en[PAYLOAD_ENABLE_BIT]) begin
                        st_next.tx_idata = hwdata[7:0];
                    end
                end
                IDX_TX_PAYLOAD_INDIRECT_ADDRESS: begin
                    if (st_reg.tx_en[PAYLOAD_ENABLE_BIT]) begin
                        st_next.tx_iaddr = hwdata[7:0];
                        if (hwdata[7:5] == PAYLOAD_TABLE_SEL) begin
                            st_next.tx_tbl[hwdata[4:0]] = st_reg.tx_idata;
                        end
                    end
                end
                IDX_RX_PAYLOAD_INDIRECT_DATA: begin
                    if (st_reg.rx_en[PAYLOAD_ENABLE_BIT]) begin
                        st_next.rx_idata = hwdata[7:0];
                    end
                end
                IDX_RX_PAYLOAD_INDIRECT_ADDRESS: begin
                    if (st_reg.rx_en[PAYLOAD_ENABLE_BIT]) begin
                        st_next.rx_iaddr = hwdata[7:0];
                        if (hwdata[7:5] == PAYLOAD_TABLE_SEL) begin
                            st_next.rx_tbl[hwdata[4:0]] = st_reg.rx_idata;
                        end
                    end
                end
                default: begin
                    if (st_reg.wr_idx >= IDX_PATTERN_INSERT_FIRST &&
                        st_reg.wr_idx <= IDX_PATTERN_INSERT_LAST) begin
                        st_next.ins[st_reg.wr_idx[1:0]] = hwdata[7:0];
                    end
                    if (st_reg.wr_idx == IDX_PATTERN_INSERT_LAST) begin
                        // whole seed is taken, the last byte from the bus itself
                        st_next.gen_lfsr = {hwdata[7:0], st_reg.ins[2],
                                            st_reg.ins[1], st_reg.ins[0]};
                        st_next.gen_run = 1'b1;
                    end
                end
            endcase
        end

        // address phase: reads sample state now, answer stands in data phase
        if (addr_phase) begin
            st_next.wr_pend = hwrite;
            st_next.wr_idx = addr_idx;
            if (!hwrite) begin
                case (addr_idx)
                    IDX_FRAMER_TEST_SELECT: rd = st_reg.fsel;
                    IDX_PATTERN_DETECTOR_CONFIG: rd = st_reg.cfg;
                    IDX_PATTERN_STATUS: begin
                        rd[STAT_DETECTOR_SYNC_FLAG_BIT] = st_reg.sync;
                        rd[STAT_BIT_ERROR_FLAG_BIT] = st_reg.bit_error_flag;
                        st_next.bit_error_flag = 1'b0;
                    end
                    IDX_PATTERN_LENGTH: rd = st_reg.len;
                    IDX_FEEDBACK_TAP: rd = st_reg.tap;
                    IDX_PATTERN_RESULT: rd = st_reg.cfg[CFG_ERROR_COUNTER_BIT] ?
                        st_reg.err_cnt[7:0] : st_reg.last_rx;
                    IDX_LOOPBACK_CONTROL: rd = st_reg.loopb;
                    IDX_RX_PAYLOAD_ENABLE: rd = st_reg.rx_en;
                    IDX_RX_PAYLOAD_INDIRECT_ADDRESS: rd = st_reg.rx_iaddr;
                    IDX_RX_PAYLOAD_INDIRECT_DATA: rd = st_reg.rx_idata;
                    IDX_TX_PAYLOAD_ENABLE: rd = st_reg.tx_en;
                    IDX_TX_PAYLOAD_INDIRECT_ADDRESS: rd = st_reg.tx_iaddr;
                    IDX_TX_PAYLOAD_INDIRECT_DATA: rd = st_reg.tx_idata;
                    default: begin
                        if (addr_idx >= IDX_PATTERN_INSERT_FIRST &&
                            addr_idx <= IDX_PATTERN_INSERT_LAST) begin
                            rd = st_reg.ins[addr_idx[1:0]];
                        end
                    end
                endcase
                st_next.hrdata = {24'h00_0000, rd};
                if (addr_idx == IDX_PATTERN_RESULT &&
                    st_reg.cfg[CFG_ERROR_COUNTER_BIT]) begin
                    st_next.hrdata = {16'h0000, st_reg.err_cnt};
                end
            end
        end

        // transmit: replace test slots of the selected framer only
        tx_hit = st_reg.gen_run && st_reg.tx_en[PAYLOAD_ENABLE_BIT] &&
                 tx_in.framer == st_reg.fsel[FRAMER_SEL_LSB +: 3] &&
                 st_reg.tx_tbl[tx_in.slot][TX_TEST_INSERT_BIT];
        g = ptg_step(st_reg.gen_lfsr, st_reg.len, st_reg.tap,
                     st_reg.cfg[CFG_REPETITIVE_PATTERN_SELECT_BIT], 1'b0, 8'h00);
        fifo_in = tx_in;
        if (tx_hit) begin
            fifo_in.data = g.data ^ {8{st_reg.cfg[CFG_TX_PATTERN_INVERT_BIT]}};
        end
        if (tx_hit && tx_in_valid && fifo_in_ready) begin
            st_next.gen_lfsr = g.st;
        end

        // receive: check test slots of the selected framer only
        rx_hit = rx_in_valid && st_reg.rx_en[PAYLOAD_ENABLE_BIT] &&
                 rx_in.framer == st_reg.fsel[FRAMER_SEL_LSB +: 3] &&
                 st_reg.rx_tbl[rx_in.slot][RX_TEST_EXTRACT_BIT];
        rxb = rx_in.data ^ {8{st_reg.cfg[CFG_RX_PATTERN_INVERT_BIT]}};
        d = ptg_step(st_reg.det_lfsr, st_reg.len, st_reg.tap,
                     st_reg.cfg[CFG_REPETITIVE_PATTERN_SELECT_BIT], ~st_reg.sync, rxb);
        if (rx_hit) begin
            st_next.det_lfsr = d.st;
            st_next.last_rx = rx_in.data;
            if (!st_reg.sync) begin
                if (d.errs != 4'd0) begin
                    st_next.good_cnt = '0;
                end else if (st_reg.good_cnt == SYNC_GOOD_BYTES - 3'd1) begin
                    st_next.sync = 1'b1;
                    st_next.good_cnt = '0;
                    st_next.bad_cnt = '0;
                end else begin
                    st_next.good_cnt = st_reg.good_cnt + 3'd1;
                end
            end else if (d.errs != 4'd0) begin
                // sticky error flag; an error beats the read that clears it
                st_next.bit_error_flag = 1'b1;
                if (st_next.err_cnt > ERR_CNT_MAX - 16'(d.errs)) begin
                    st_next.err_cnt = ERR_CNT_MAX;
                end else begin
                    st_next.err_cnt = st_next.err_cnt + 16'(d.errs);
                end
                if (st_reg.bad_cnt == LOSS_BAD_BYTES - 3'd1) begin
                    // without auto resync the detector holds its lock
                    if (st_reg.cfg[CFG_AUTO_RESYNC_BIT]) begin
                        st_next.sync = 1'b0;
                        st_next.good_cnt = '0;
                    end
                    st_next.bad_cnt = '0;
                end else begin
                    st_next.bad_cnt = st_reg.bad_cnt + 3'd1;
                end
            end else begin
                st_next.bad_cnt = '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.fsel <= REG_RESET;
            st_reg.cfg <= REG_RESET;
            st_reg.loopb <= REG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////

    // fifo absorbs line-side stalls; its ready throttles the framer source
    ptg_fifo #(
        .WIDTH($bits(ptg_slot_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .in_valid(tx_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(tx_out_ready),
        .out_data(fifo_out)
    );

    assign tx_in_ready = fifo_in_ready;
    assign tx_out_valid = fifo_out_valid;
    assign tx_out = fifo_out;
    assign hreadyout = st_reg.hready;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign test_framer = st_reg.fsel[FRAMER_SEL_LSB +: 3];
    assign diag_loopback = st_reg.loopb[LOOPBACK_DIAG_DIGITAL_BIT];

endmodule // ptg_top

// File: ptg_top_test.sv
// ptg_top_test: register and stream tests of ptg_top through its AHB port.
// assumes ptg_line_model loops tx back to rx; one 20 MHz clock.
`timescale 1ns/10ps
module ptg_top_test
    import ptg_pkg::*;
;
    logic core_clk, srst, hsel, hwrite, hready, hreadyout, hresp, stall, corrupt;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, test_framer;
    logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready, rx_in_valid, diag_loopback;
    ptg_slot_type tx_in, tx_out, rx_in;
    ptg_slot_type outq[$];
    int failures, n_checks;
    assign hready = hreadyout;
    ptg_top #(.FIFO_DEPTH(4)) uut (.core_clk(core_clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in(tx_in),
        .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_out(tx_out),
        .rx_in_valid(rx_in_valid), .rx_in(rx_in), .test_framer(test_framer),
        .diag_loopback(diag_loopback));
    ptg_line_model u_line (.core_clk(core_clk), .srst(srst), .stall(stall),
        .corrupt(corrupt), .tx_out_valid(tx_out_valid), .tx_out(tx_out),
        .tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid), .rx_in(rx_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_hready();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) failures++;
    endtask
    task automatic ahb(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr_en;
        wait_hready();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_hready();
        rd = hrdata;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        ahb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask
    task automatic put(input logic [2:0] fr, input logic [4:0] sl, input logic [7:0] d);
        int n;
        n = 0;
        tx_in <= '{fr, sl, d};
        tx_in_valid <= 1'b1;
        @(posedge core_clk);
        while (tx_in_ready !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) failures++;
        tx_in_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic take(input logic [7:0] e);
        int n;
        ptg_slot_type s;
        n = 0;
        while (outq.size() == 0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        s = '0;
        s.data = ~e;
        if (outq.size() > 0) begin
            s = outq.pop_front();
        end
        check({24'h00_0000, s.data}, {24'h00_0000, e});
    endtask
    task automatic send(input logic [2:0] fr, input logic [4:0] sl, input logic [7:0] d,
        input logic [7:0] e);
        put(fr, sl, d);
        take(e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
            outq.push_back(tx_out);
        end
    end
    initial begin : watchdog
        #1_000_000;
        failures++;
        stop_test();
    end
    initial begin
        srst = 1'b1; hsel = 1'b1; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = '0; tx_in_valid = 1'b0; tx_in = '0;
        stall = 1'b0; corrupt = 1'b0; failures = 0; n_checks = 0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdc(IDX_FRAMER_TEST_SELECT, 32'h0000_0000);
        rdc(IDX_LOOPBACK_CONTROL, 32'h0000_0000);
        wr(8'h05, 8'h5A);
        rdc(8'h05, 32'h0000_0000);
        $display("reset and unmapped test done");
        wr(IDX_FRAMER_TEST_SELECT, 8'h20);
        rdc(IDX_FRAMER_TEST_SELECT, 32'h0000_0020);
        check({29'h0, test_framer}, 32'h0000_0001);
        wr(IDX_LOOPBACK_CONTROL, 8'h04);
        check({31'h0, diag_loopback}, 32'h0000_0001);
        rdc(IDX_LOOPBACK_CONTROL, 32'h0000_0004);
        $display("select and loopback test done");
        wr(IDX_TX_PAYLOAD_INDIRECT_DATA, 8'h08);
        wr(IDX_TX_PAYLOAD_INDIRECT_ADDRESS, 8'h22);
        wr(IDX_PATTERN_DETECTOR_CONFIG, 8'h92);
        wr(IDX_PATTERN_LENGTH, 8'h00);
        wr(IDX_FEEDBACK_TAP, 8'h00);
        for (int i = 0; i < 4; i++) wr(IDX_PATTERN_INSERT_FIRST + 8'(i), 8'hFF);
        send(3'h1, 5'h02, 8'hAA, 8'hAA);
        rdc(IDX_TX_PAYLOAD_INDIRECT_ADDRESS, 32'h0000_0000);
        wr(IDX_TX_PAYLOAD_ENABLE, 8'h01);
        for (int s = 0; s < 32; s++) begin
            wr(IDX_TX_PAYLOAD_INDIRECT_DATA, 8'h00);
            wr(IDX_TX_PAYLOAD_INDIRECT_ADDRESS, 8'h20 | 8'(s));
        end
        wr(IDX_TX_PAYLOAD_INDIRECT_DATA, 8'h08);
        wr(IDX_TX_PAYLOAD_INDIRECT_ADDRESS, 8'h22);
        send(3'h1, 5'h02, 8'hAA, 8'hFF);
        send(3'h1, 5'h03, 8'hAA, 8'hAA);
        send(3'h0, 5'h02, 8'h55, 8'h55);
        $display("tx slot insertion test done");
        wr(IDX_PATTERN_INSERT_FIRST, 8'hFE);
        send(3'h1, 5'h02, 8'hAA, 8'hFF);
        wr(IDX_PATTERN_INSERT_LAST, 8'hFF);
        send(3'h1, 5'h02, 8'hAA, 8'h00);
        wr(IDX_PATTERN_DETECTOR_CONFIG, 8'hB2);
        send(3'h1, 5'h02, 8'hAA, 8'hFF);
        wr(IDX_PATTERN_DETECTOR_CONFIG, 8'h92);
        wr(IDX_PATTERN_INSERT_FIRST, 8'hFF);
        wr(IDX_PATTERN_INSERT_LAST, 8'hFF);
        $display("pattern load test done");
        wr(IDX_RX_PAYLOAD_ENABLE, 8'h01);
        wr(IDX_RX_PAYLOAD_INDIRECT_DATA, 8'h80);
        wr(IDX_RX_PAYLOAD_INDIRECT_ADDRESS, 8'h22);
        repeat (6) send(3'h1, 5'h02, 8'hAA, 8'hFF);
        ahb(1'b0, IDX_PATTERN_STATUS, 8'h00);
        ahb(1'b0, IDX_PATTERN_STATUS, 8'h00);
        check(rd & 32'h0000_0014, 32'h0000_0010);
        wr(IDX_PATTERN_RESULT, 8'h00);
        corrupt <= 1'b1;
        send(3'h1, 5'h02, 8'hAA, 8'hFF);
        corrupt <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdc(IDX_PATTERN_RESULT, 32'h0000_0001);
        ahb(1'b0, IDX_PATTERN_STATUS, 8'h00);
        check(rd & 32'h0000_0014, 32'h0000_0014);
        $display("rx detector test done");
        stall <= 1'b1;
        for (int i = 1; i <= 4; i++) put(3'h1, 5'h03, 8'(i));
        check({31'h0, tx_in_ready}, 32'h0000_0000);
        stall <= 1'b0;
        for (int i = 1; i <= 4; i++) take(8'(i));
        @(posedge core_clk);
        check({31'h0, tx_out_valid}, 32'h0000_0000);
        wr(IDX_PATTERN_LENGTH, 8'h18);
        wr(IDX_FEEDBACK_TAP, 8'h02);
        wr(IDX_PATTERN_DETECTOR_CONFIG, 8'h82);
        wr(IDX_PATTERN_INSERT_LAST, 8'hFF);
        send(3'h1, 5'h02, 8'hAA, 8'h1C);
        $display("fifo test done");
        stop_test();
    end
endmodule // ptg_top_test
